// file: core/sbd_digit_out.sv
// Scanned BCD digit output port of a four and a half digit meter.
`timescale 1ns/1ns

// Overview of the port as seen from the far side.
// The block owns one scan position that walks through five slots: the four
// full digits from the lowest upward, then a reserved slot for the half digit.
// Every slot lasts SCAN_CYC system clocks. The scan clock is high for the
// first half of a slot and low for the second, so its falling edge sits in
// the middle of a slot, well away from the moment the lines change.
//
// A new reading is taken into a shadow copy on any cycle with load_req high.
// It only reaches the display at the next slot boundary. Until then the
// update output stays high; its fall marks the boundary at which the new
// reading is in force. Capture logic that waits for the first marker after
// that fall sees one consistent reading unless a new load swaps in during that scan.
//
// Limitation: a load that arrives in every cycle keeps update
// high and keeps replacing the shadow, so the display shows the last one.
// Limitation: after reset all port lines but update stay low for the first slot, since
// the first step is made only on the first slot strobe of the divider.
module sbd_digit_out
#(
  parameter int SCAN_CYC = sbd_pkg::SCAN_PERIOD_CYC
)
(
  // Clock and reset.
  input  wire logic                                         clk_sys,
  input  wire logic                                         rst_b,
  // New reading from the measurement logic, taken on load_req.
  input  wire logic                                         load_req,
  input  wire logic [sbd_pkg::NUM_DIGITS*sbd_pkg::BCD_W-1:0] new_digits,
  input  wire logic                                         new_half_one,
  input  wire logic                                         new_negative,
  input  wire logic [sbd_pkg::SLOT_W-1:0]                    new_dp_slot,
  // Scanned display port.
  output logic                                              scan_clk,
  output logic                                              lowest_digit_marker,
  output logic [sbd_pkg::NUM_DIGITS-1:0]                    digit_en,
  output logic [sbd_pkg::BCD_W-1:0]                         bcd,
  output logic                                              decimal_point,
  output logic                                              top_half_digit,
  output logic                                              polarity,
  output logic                                              update
);
  import sbd_pkg::*;

  // Whole state of the port in one record, registered in one place.
  typedef struct packed {
    // Scan position and the flops that drive the port directly.
    sbd_slot_e                         slot;
    logic                              scan_clk;
    logic                              marker;
    logic [NUM_DIGITS-1:0]             digit_en;
    logic [BCD_W-1:0]                  bcd;
    logic                              dp;
    logic                              one;
    logic                              pol;
    logic                              update;
    // Shadow reading waiting for the next slot boundary.
    logic                              pending;
    logic [NUM_DIGITS*BCD_W-1:0]       sh_digits;
    logic                              sh_half;
    logic                              sh_neg;
    logic [SLOT_W-1:0]                 sh_dp;
    // Reading in force on the display.
    logic [NUM_DIGITS*BCD_W-1:0]       disp_digits;
    logic                              disp_half;
    logic                              disp_neg;
    logic [SLOT_W-1:0]                 disp_dp;
  } sbd_out_s;

  sbd_out_s st_q;
  sbd_out_s st_d;

  // Strobes from the divider travel together in one bundle.
  sbd_tick_if tick ();

  // Slot timing comes from the divider; one slot is one scan clock period.
  sbd_scan_div #(
    .SCAN_CYC (SCAN_CYC)
  ) u_div (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .tick    (tick)
  );

  // Sequencer. Data for the new slot is set up in the same cycle as the
  // scan clock rises, so it is stable for the whole high and low halves.
  always_comb
  begin
    sbd_slot_e         nxt;
    logic [SLOT_W-1:0] idx;
    nxt  = st_q.slot;
    idx  = '0;
    st_d = st_q;
    // Scan clock falls mid-slot, giving capture logic a settled edge.
    if (tick.half_tick)
    begin
      st_d.scan_clk = 1'b0;
    end
    if (tick.slot_tick)
    begin
      // A pending reading is swapped in only at a slot boundary, so no
      // slot ever shows a mix of old and new digits.
      if (st_q.pending)
      begin
        st_d.disp_digits = st_q.sh_digits;
        st_d.disp_half   = st_q.sh_half;
        st_d.disp_neg    = st_q.sh_neg;
        st_d.disp_dp     = st_q.sh_dp;
        st_d.pending     = 1'b0;
        st_d.update      = 1'b0;
      end
      unique case (st_q.slot)
        SLOT_D0:  nxt = SLOT_D1;
        SLOT_D1:  nxt = SLOT_D2;
        SLOT_D2:  nxt = SLOT_D3;
        SLOT_D3:  nxt = SLOT_TOP;
        SLOT_TOP: nxt = SLOT_D0;
        default:  nxt = SLOT_D0;
      endcase
      // The decimal point and the digit lines use the reading that is in
      // force after a swap in this same cycle, hence st_d and not st_q.
      idx           = SLOT_W'(nxt);
      st_d.slot     = nxt;
      st_d.scan_clk = 1'b1;
      st_d.marker   = (nxt == SLOT_D0);
      st_d.dp       = (st_d.disp_dp == idx);
      if (nxt == SLOT_TOP)
      begin
        // Reserved slot: no full digit lit, half digit value on the lines.
        st_d.digit_en = '0;
        st_d.bcd      = {3'h0, st_d.disp_half};
      end
      else
      begin
        st_d.digit_en = EN_ONE << idx[1:0];
        st_d.bcd      = st_d.disp_digits[idx[1:0]*BCD_W +: BCD_W];
      end
    end
    // Dedicated half-digit and sign outputs follow the loaded reading.
    // They change only when a reading is swapped in, which is always on a
    // slot boundary, so they never move in the middle of a slot.
    st_d.one = st_d.disp_half;
    st_d.pol = st_d.disp_neg;
    // A new result raises update; a request in the swap cycle still wins.
    if (load_req)
    begin
      st_d.sh_digits = new_digits;
      st_d.sh_half   = new_half_one;
      st_d.sh_neg    = new_negative;
      st_d.sh_dp     = new_dp_slot;
      st_d.pending   = 1'b1;
      st_d.update    = 1'b1;
    end
  end

  // State register; the reserved slot at reset makes the first step land
  // on the lowest digit.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q             <= '0;
      st_q.slot        <= SLOT_TOP;
      st_q.bcd         <= BCD_RST;
      st_q.disp_digits <= DIGITS_RST;
      st_q.sh_digits   <= DIGITS_RST;
      st_q.disp_dp     <= DP_NONE;
      st_q.sh_dp       <= DP_NONE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // All outputs come straight from state flops, so no decode glitch can
  // reach the far side between clock edges.
  assign scan_clk            = st_q.scan_clk;
  assign lowest_digit_marker = st_q.marker;
  assign digit_en            = st_q.digit_en;
  assign bcd                 = st_q.bcd;
  assign decimal_point       = st_q.dp;
  assign top_half_digit      = st_q.one;
  assign polarity            = st_q.pol;
  assign update              = st_q.update;

endmodule : sbd_digit_out

// file: core/sbd_pkg.sv
// Shared constants and types for the scanned BCD digit output block.
package sbd_pkg;

  // System clock period and scan slot period.
  localparam int CLK_PERIOD_NS  = 4;
  localparam int SCAN_PERIOD_NS = 250000;
  // One slot is one scan clock period of 4 kHz (whole cycles).
  localparam int SCAN_PERIOD_CYC = SCAN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SCAN_CNT_W      = 17;

  // Display geometry.
  localparam int NUM_DIGITS = 4;
  localparam int BCD_W      = 4;
  localparam int SLOT_W     = 3;

  // Decimal point selector value meaning no point shown.
  localparam logic [SLOT_W-1:0] DP_NONE = 3'h7;

  // Reset values and the lowest digit enable.
  localparam logic [NUM_DIGITS*BCD_W-1:0] DIGITS_RST = 16'h0000;
  localparam logic [BCD_W-1:0]            BCD_RST    = 4'h0;
  localparam logic [NUM_DIGITS-1:0]       EN_ONE     = 4'h1;

  // Scan slots, lowest digit first, then the reserved half-digit slot.
  typedef enum logic [SLOT_W-1:0] {
    SLOT_D0,
    SLOT_D1,
    SLOT_D2,
    SLOT_D3,
    SLOT_TOP
  } sbd_slot_e;

endpackage : sbd_pkg

// file: core/sbd_scan_div.sv
// Divider that makes the slot and mid-slot enables from the system clock.
`timescale 1ns/1ns
module sbd_scan_div
#(
  parameter int SCAN_CYC = sbd_pkg::SCAN_PERIOD_CYC
)
(
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Strobes out.
  sbd_tick_if.src   tick
);
  import sbd_pkg::*;

  typedef struct packed {
    logic [SCAN_CNT_W-1:0] cnt;
    logic                  slot_tick;
    logic                  half_tick;
  } sbd_div_s;

  sbd_div_s st_q;
  sbd_div_s st_d;

  // Free-running count; the slot strobe ends each period, the half strobe
  // marks its middle so the scan clock can fall there.
  always_comb
  begin
    st_d           = st_q;
    st_d.slot_tick = 1'b0;
    st_d.half_tick = 1'b0;
    if (st_q.cnt == SCAN_CNT_W'(SCAN_CYC - 1))
    begin
      st_d.cnt       = '0;
      st_d.slot_tick = 1'b1;
    end
    else
    begin
      st_d.cnt = st_q.cnt + SCAN_CNT_W'(1);
    end
    if (st_q.cnt == SCAN_CNT_W'(SCAN_CYC / 2 - 1))
    begin
      st_d.half_tick = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tick.slot_tick = st_q.slot_tick;
  assign tick.half_tick = st_q.half_tick;

endmodule : sbd_scan_div

// file: core/sbd_tick_if.sv
// Timing strobes passed from the scan divider to the output sequencer.
`timescale 1ns/1ns
interface sbd_tick_if;
  logic slot_tick;
  logic half_tick;
  modport src (output slot_tick, output half_tick);
  modport snk (input slot_tick, input half_tick);
endinterface : sbd_tick_if

// file: sim/sbd_cap_model.sv
// Capture logic that stores one whole scanned reading.
`timescale 1ns/1ns
module sbd_cap_model
(
  // Scanned port and store request.
  input wire logic scan_clk,
  input wire logic lowest_digit_marker,
  input wire logic [3:0] bcd,
  input wire logic decimal_point,
  input wire logic polarity,
  input wire logic update,
  input wire logic store_req,
  // Captured reading.
  output logic [15:0] cap_digits,
  output logic cap_half,
  output logic cap_neg,
  output logic [2:0] cap_dp,
  output logic cap_ready
);
  int slot = 5;
  logic fell = 1'b0;
  // Only a fall after the request counts, so a scan in mid-update is skipped.
  // A fresh rise of update withdraws the mark, so a reading that is replaced
  // again before its scan begins is never taken.
  always @(update or posedge store_req) fell <= !store_req && !update;
  // The scan clock fall is mid-slot, where the lines have settled.
  always @(negedge scan_clk or posedge store_req)
    if (store_req)
    begin
      {cap_digits, cap_half, cap_neg, cap_ready} <= '0;
      cap_dp <= 3'h7;
      slot = 5;
    end
    else if (!cap_ready)
    begin
      if (lowest_digit_marker && fell) slot = 0;
      if (slot < 4) cap_digits[slot*4 +: 4] <= bcd;
      if (slot < 5 && decimal_point) cap_dp <= 3'(slot);
      if (slot == 4) {cap_half, cap_neg, cap_ready} <= {bcd[0], polarity, 1'b1};
      if (slot < 5) slot = slot + 1;
    end
endmodule : sbd_cap_model

// file: sim/sbd_digit_out_asserts.sv
// Port timing checks of the scanned digit output.
`timescale 1ns/1ns
module sbd_digit_out_asserts
#(parameter int SCAN_CYC = 8)
(
  // Clock, reset and watched ports.
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic load_req,
  input wire logic scan_clk,
  input wire logic lowest_digit_marker,
  input wire logic [sbd_pkg::NUM_DIGITS-1:0] digit_en,
  input wire logic [sbd_pkg::BCD_W-1:0] bcd,
  input wire logic decimal_point,
  input wire logic top_half_digit,
  input wire logic polarity,
  input wire logic update
);
  import sbd_pkg::*;
  localparam int HALF = SCAN_CYC / 2;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // A slot boundary is a rise of the scan clock.
  sequence s_edge; $rose(scan_clk); endsequence
  sequence s_top; s_edge ##0 ($past(digit_en) == 4'h8); endsequence
  sequence s_wrap; s_edge ##0 ($past(digit_en) == 4'h0); endsequence
  a_scan_period: assert property (s_edge |-> ##SCAN_CYC $rose(scan_clk))
    else $error("scan period");
  a_scan_half: assert property (s_edge |-> ##HALF $fell(scan_clk))
    else $error("scan duty");
  a_one_digit: assert property ($onehot0(digit_en))
    else $error("two digits on");
  a_digit_step: assert property (s_edge ##0 ($past(digit_en) inside {4'h1, 4'h2, 4'h4})
    |-> digit_en == ($past(digit_en) << 1))
    else $error("bad step");
  a_top_slot: assert property (s_top |-> digit_en == 4'h0 && bcd == {3'h0, top_half_digit})
    else $error("bad top slot");
  a_wrap_low: assert property (s_wrap |-> digit_en == 4'h1 && lowest_digit_marker)
    else $error("bad wrap");
  a_marker_low: assert property (lowest_digit_marker == (digit_en == 4'h1))
    else $error("marker slot");
  a_slot_hold: assert property (!$rose(scan_clk) |-> $stable(bcd) && $stable(decimal_point))
    else $error("slot changed");
  a_upd_swap: assert property ($fell(update) |-> $rose(scan_clk))
    else $error("update fall");
  a_sign_hold: assert property (!$rose(scan_clk) |-> $stable(polarity) && $stable(top_half_digit))
    else $error("sign changed");
endmodule : sbd_digit_out_asserts

// file: sim/sbd_digit_out_tb_top.sv
// Random and corner readings sent through the scanned port and recaptured.
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module sbd_digit_out_tb_top;
  import sbd_pkg::*;
  // A short slot keeps a full scan to a few dozen cycles.
  localparam int SC = 8;
  logic clk_sys = 1'b0, rst_b = 1'b0, load_req = 1'b0, store_req = 1'b0;
  logic new_half_one = 1'b0, new_negative = 1'b0, cap_half, cap_neg, cap_ready;
  logic [15:0] new_digits = 16'h0000, cap_digits;
  logic [2:0] new_dp_slot = 3'h7, cap_dp;
  logic scan_clk, lowest_digit_marker, decimal_point, top_half_digit, polarity, update;
  logic [3:0] digit_en, bcd;
  int err_count = 0, check_count = 0, tn = 0;
  always #2 clk_sys = ~clk_sys;
  sbd_digit_out #(.SCAN_CYC(SC)) uut (.clk_sys(clk_sys), .rst_b(rst_b), .load_req(load_req),
    .new_digits(new_digits), .new_half_one(new_half_one), .new_negative(new_negative),
    .new_dp_slot(new_dp_slot), .scan_clk(scan_clk), .lowest_digit_marker(lowest_digit_marker),
    .digit_en(digit_en), .bcd(bcd), .decimal_point(decimal_point),
    .top_half_digit(top_half_digit), .polarity(polarity), .update(update));
  sbd_cap_model cap (.scan_clk(scan_clk), .lowest_digit_marker(lowest_digit_marker),
    .bcd(bcd), .decimal_point(decimal_point), .polarity(polarity), .update(update),
    .store_req(store_req), .cap_digits(cap_digits), .cap_half(cap_half),
    .cap_neg(cap_neg), .cap_dp(cap_dp), .cap_ready(cap_ready));
  // Four random decimal digits, lowest first.
  function automatic logic [15:0] rand_bcd();
    logic [15:0] v;
    for (int i = 0; i < 4; i++) v[i*4 +: 4] = 4'($urandom % 10);
    return v;
  endfunction : rand_bcd
  // Only slots 0 to 4 can carry a point.
  function automatic logic [2:0] exp_dp(input logic [2:0] p);
    return (p <= 3'h4) ? p : 3'h7;
  endfunction : exp_dp
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out
  // Clear capture, load (with an overwrite one cycle later if two), then recapture.
  task automatic run(input logic [15:0] d, input logic h, n, two, input logic [2:0] p);
    int i;
    store_req <= 1'b1;
    @(posedge clk_sys);
    @(posedge clk_sys);
    `CHK("ready_clr", 1'b0, cap_ready)
    store_req <= 1'b0;
    load_req <= 1'b1;
    {new_digits, new_half_one, new_negative, new_dp_slot} <= two ? {rand_bcd(), ~h, ~n, 3'h7}
      : {d, h, n, p};
    @(posedge clk_sys);
    {new_digits, new_half_one, new_negative, new_dp_slot} <= {d, h, n, p};
    load_req <= two;
    @(posedge clk_sys);
    load_req <= 1'b0;
    for (i = 0; i < 16 * SC && cap_ready !== 1'b1; i++) @(posedge clk_sys);
    if (i >= 16 * SC)
    begin
      err_count++;
      close_out();
    end
    `CHK("digits", d, cap_digits)
    `CHK("half", h, cap_half)
    `CHK("one_out", h, top_half_digit)
    `CHK("neg", n, cap_neg)
    `CHK("polarity", n, polarity)
    `CHK("dp", exp_dp(p), cap_dp)
    tn++;
    $display("test %0d done", tn);
  endtask : run
  initial
  begin
    void'($urandom(32'hDBFD));
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Every point code, the none codes 5 to 7 among them.
    for (int p = 0; p < 8; p++) run(rand_bcd(), p[0], p[1], p[2], 3'(p));
    run(16'h9999, 1'b1, 1'b1, 1'b1, 3'h4);
    run(16'h0000, 1'b0, 1'b0, 1'b0, 3'h0);
    for (int k = 0; k < 4; k++) run(rand_bcd(), 1'($urandom), 1'($urandom), 1'b0, 3'($urandom % 5));
    close_out();
  end
endmodule : sbd_digit_out_tb_top
bind sbd_digit_out sbd_digit_out_asserts #(.SCAN_CYC(SCAN_CYC)) chk (.clk_sys(clk_sys),
  .rst_b(rst_b), .load_req(load_req), .scan_clk(scan_clk), .digit_en(digit_en), .bcd(bcd),
  .lowest_digit_marker(lowest_digit_marker), .decimal_point(decimal_point),
  .top_half_digit(top_half_digit), .polarity(polarity), .update(update));
